//--- design/pwm_clk_pkg.sv
// Package for the PWM timer clock selection and counter control block.
// Assumes a classic Wishbone slave with 32-bit data on one 10 MHz clock.
package pwm_clk_pkg;

	// ****************************************************************
	// Register map (printed offsets are not word aligned: indices)
	// ****************************************************************
	localparam logic [15:0] CLK_SETUP_IDX    = 16'h5069;
	localparam logic [15:0] CNT_CONTROL_IDX  = 16'h5420;
	localparam int          ADDR_W           = 18;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int DIV_LSB       = 4;
	localparam int SRC_LSB       = 2;
	localparam int GATE_BIT      = 0;
	localparam int HALF_BIT      = 6;
	localparam int PICK_LSB      = 4;
	localparam int BUF_BIT       = 3;
	localparam int TRIG_BIT      = 2;
	localparam int CLR_BIT       = 1;
	localparam int RUN_BIT       = 0;

	// ****************************************************************
	// Reset values and codes
	// ****************************************************************
	localparam logic [7:0]  CLK_SETUP_RST    = 8'h00;
	localparam logic [6:0]  CNT_CONTROL_RST  = 7'h00;
	localparam logic [1:0]  SRC_EXTERNAL     = 2'h3;
	localparam logic [1:0]  SRC_FAST_B       = 2'h0;
	localparam logic [1:0]  SRC_SLOW         = 2'h2;
	localparam logic [3:0]  DIV_FAST_MAX     = 4'hE;
	localparam logic [3:0]  DIV_SLOW_MAX     = 4'h8;
	localparam logic [3:0]  DIV_TICK_256     = 4'h9;
	localparam int          PRESC_W          = 14;

	typedef struct packed {
		logic [3:0] clock_divider_select;
		logic [1:0] count_source_select;
		logic       count_clock_gate;
	} clk_setup_t;

	typedef struct packed {
		logic       half_period_mode;
		logic [1:0] counter_pick;
		logic       compare_buffering;
		logic       trigger_mode_select;
		logic       counter_run;
	} cnt_control_t;

endpackage : pwm_clk_pkg

//--- design/pwm_prescaler.sv
// Power-of-two prescaler driven by source tick enables.
// Assumes source ticks are one-cycle pulses on clk_i.
`timescale 1ns/1ns
module pwm_prescaler
	import pwm_clk_pkg::*;
#(
	parameter int WIDTH = PRESC_W
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Tick in, ratio code, tick out
	input  wire logic             tick_i,
	input  wire logic [3:0]       code_i,
	output logic                  tick_o
);
	logic [WIDTH-1:0] stage_r;
	logic [WIDTH:0]   carry;

	// Ripple counter; carry k means 2**k source ticks have elapsed
	always_comb begin
		carry[0] = tick_i;
		for (int k = 0; k < WIDTH; k++) begin
			carry[k+1] = carry[k] & stage_r[k];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage_r <= '0;
		end else if (tick_i) begin
			stage_r <= stage_r + WIDTH'(1);
		end
	end

	always_comb begin
		tick_o = 1'b0;
		if (int'(code_i) <= WIDTH) begin
			tick_o = carry[code_i];
		end
	end

endmodule : pwm_prescaler

//--- design/pwm_timer_unit.sv
// Clock selection and counter control for one PWM timer channel.
// Assumes oscillator and external ticks arrive as asynchronous levels.
//
// Operation
// - Divide count clock by power-of-two code
// - Two-bit field selects count clock source
// - Gate bit passes divided clock; resets 0
// - Half-period mode bit, resets to 0
// - Run bit runs counter; resets stopped
// - Writing counter reset clears; reads 0
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
module pwm_timer_unit
	import pwm_clk_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	// Clock sources, asynchronous levels
	input  wire logic              fast_osc_a_i,
	input  wire logic              fast_osc_b_i,
	input  wire logic              slow_osc_i,
	input  wire logic              ext_clk_i,
	input  wire logic              regulated_256hz_tick_i,
	// Counter core side
	input  wire logic              period_end_i,
	output logic                   count_en_o,
	output logic                   counter_clear_o,
	output logic                   counter_run_o,
	output logic                   half_period_mode_o,
	output logic                   compare_buffering_o,
	output logic [1:0]             counter_pick_o
);

	// ****************************************************************
	// Register bus
	// ****************************************************************
	clk_setup_t   setup_r;
	cnt_control_t ctl_r;
	logic         ack_r;
	logic [31:0]  rdata_r;
	logic         clear_r;
	logic         bus_req;
	logic         hit_setup;
	logic         hit_ctl;
	logic         wr_setup;
	logic         wr_ctl;

	assign bus_req   = cyc_i & stb_i & ~ack_r;
	assign hit_setup = adr_i == {CLK_SETUP_IDX, 2'b00};
	assign hit_ctl   = adr_i == {CNT_CONTROL_IDX, 2'b00};
	assign wr_setup  = bus_req & we_i & hit_setup & sel_i[0];
	assign wr_ctl    = bus_req & we_i & hit_ctl & sel_i[0];

	// One wait state: ack one cycle after strobe, dropped next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (bus_req & ~we_i) begin
			rdata_r <= 32'h0000_0000;
			if (hit_setup) begin
				rdata_r[7:0] <= {setup_r.clock_divider_select,
					setup_r.count_source_select, 1'b0,
					setup_r.count_clock_gate};
			end else if (hit_ctl) begin
				// Counter reset bit always reads zero
				rdata_r[6:0] <= {ctl_r.half_period_mode,
					ctl_r.counter_pick, ctl_r.compare_buffering,
					ctl_r.trigger_mode_select, 1'b0,
					ctl_r.counter_run};
			end
		end
	end

	assign ack_o = ack_r;
	assign dat_o = rdata_r;

	// ****************************************************************
	// Clock setup register
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Reserved bit 1 has no storage, so it leaves the reset word
			setup_r <= clk_setup_t'({CLK_SETUP_RST[7:2],
				CLK_SETUP_RST[0]});
		end else if (wr_setup) begin
			setup_r.clock_divider_select <= dat_i[DIV_LSB +: 4];
			setup_r.count_source_select  <= dat_i[SRC_LSB +: 2];
			setup_r.count_clock_gate     <= dat_i[GATE_BIT];
		end
	end

	// ****************************************************************
	// Counter control register
	// ****************************************************************
	logic one_shot_done;

	// One-shot stop wins over a run write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Clear bit is a strobe, not stored, so it leaves the reset word
			ctl_r <= cnt_control_t'({CNT_CONTROL_RST[6:2],
				CNT_CONTROL_RST[0]});
		end else begin
			if (wr_ctl) begin
				ctl_r.half_period_mode    <= dat_i[HALF_BIT];
				ctl_r.counter_pick        <= dat_i[PICK_LSB +: 2];
				ctl_r.compare_buffering   <= dat_i[BUF_BIT];
				ctl_r.trigger_mode_select <= dat_i[TRIG_BIT];
				ctl_r.counter_run         <= dat_i[RUN_BIT];
			end
			if (one_shot_done) begin
				ctl_r.counter_run <= 1'b0;
			end
		end
	end

	// Clear is a one-cycle pulse, never stored as a bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clear_r <= 1'b0;
		end else begin
			clear_r <= wr_ctl & dat_i[CLR_BIT];
		end
	end

	// ****************************************************************
	// Source synchronisers and edge ticks
	// ****************************************************************
	logic [4:0] src_meta_r;
	logic [4:0] src_sync_r;
	logic [4:0] src_prev_r;
	logic [4:0] src_tick;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_meta_r <= 5'h00;
			src_sync_r <= 5'h00;
			src_prev_r <= 5'h00;
		end else begin
			src_meta_r <= {regulated_256hz_tick_i, ext_clk_i, slow_osc_i,
				fast_osc_a_i, fast_osc_b_i};
			src_sync_r <= src_meta_r;
			src_prev_r <= src_sync_r;
		end
	end

	assign src_tick = src_sync_r & ~src_prev_r;

	// ****************************************************************
	// Source select, division and gate
	// ****************************************************************
	logic sel_tick;
	logic div_tick;
	logic code_ok;
	logic gated_tick;

	always_comb begin
		unique case (setup_r.count_source_select)
			SRC_FAST_B:   sel_tick = src_tick[0];
			SRC_SLOW:     sel_tick = src_tick[2];
			SRC_EXTERNAL: sel_tick = src_tick[3];
			2'h1:         sel_tick = src_tick[1];
		endcase
	end

	pwm_prescaler #(
		.WIDTH (PRESC_W)
	) u_presc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_i (sel_tick),
		.code_i (setup_r.clock_divider_select),
		.tick_o (div_tick)
	);

	// Reserved codes stop the clock rather than guess a ratio
	always_comb begin
		code_ok    = 1'b0;
		gated_tick = 1'b0;
		if (setup_r.count_source_select == SRC_SLOW) begin
			if (setup_r.clock_divider_select <= DIV_SLOW_MAX) begin
				code_ok    = 1'b1;
				gated_tick = div_tick;
			end else if (setup_r.clock_divider_select == DIV_TICK_256) begin
				code_ok    = 1'b1;
				gated_tick = src_tick[4];
			end
		end else if (setup_r.clock_divider_select <= DIV_FAST_MAX) begin
			code_ok    = 1'b1;
			gated_tick = div_tick;
		end
	end

	assign count_en_o = gated_tick & setup_r.count_clock_gate
		& ctl_r.counter_run;

	assign one_shot_done = ctl_r.trigger_mode_select & ctl_r.counter_run
		& period_end_i & count_en_o;

	assign counter_clear_o     = clear_r;
	assign counter_run_o       = ctl_r.counter_run;
	assign half_period_mode_o  = ctl_r.half_period_mode;
	assign compare_buffering_o = ctl_r.compare_buffering;
	assign counter_pick_o      = ctl_r.counter_pick;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_req_acked;
		bus_req ##1 ack_o;
	endsequence

	a_ack_one_wait: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req |=> ack_o ##1 !ack_o)
		else $error("ack timing wrong");

	a_gate_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
		!setup_r.count_clock_gate |-> !count_en_o)
		else $error("count enable while gate off");

	a_stop_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctl_r.counter_run |-> !count_en_o)
		else $error("count enable while stopped");

	a_clear_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_ctl && dat_i[CLR_BIT]) |=> counter_clear_o ##1 !counter_clear_o)
		else $error("clear pulse wrong");

	a_clear_reads_zero: assert property (@(posedge clk_i)
		disable iff (rst_i) (s_req_acked and (hit_ctl && !we_i) ##1 1'b1)
		|-> dat_o[CLR_BIT] == 1'b0)
		else $error("counter reset bit read as one");

	a_oneshot_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		one_shot_done |=> !counter_run_o)
		else $error("one shot did not stop");

	a_repeat_runs: assert property (@(posedge clk_i) disable iff (rst_i)
		(counter_run_o && !ctl_r.trigger_mode_select && !wr_ctl)
		|=> counter_run_o)
		else $error("repeat mode stopped");

	a_half_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl |=> half_period_mode_o == $past(dat_i[HALF_BIT]))
		else $error("half mode not stored");

	a_reserved_blocks: assert property (@(posedge clk_i)
		disable iff (rst_i) !code_ok |-> !count_en_o)
		else $error("reserved code passed clock");

	a_ext_source: assert property (@(posedge clk_i) disable iff (rst_i)
		(setup_r.count_source_select == SRC_EXTERNAL
			&& setup_r.clock_divider_select == 4'h0)
		|-> count_en_o == (src_tick[3] & setup_r.count_clock_gate
			& ctl_r.counter_run))
		else $error("external source not selected");

	// Reset values, seen at the first edge after release
	a_gate_resets: assert property (@(posedge clk_i)
		$fell(rst_i) |-> !setup_r.count_clock_gate)
		else $error("gate not cleared by reset");

	a_half_resets: assert property (@(posedge clk_i)
		$fell(rst_i) |-> !half_period_mode_o)
		else $error("half mode not cleared by reset");

	a_run_resets: assert property (@(posedge clk_i)
		$fell(rst_i) |-> !counter_run_o)
		else $error("run not cleared by reset");

	a_trig_resets: assert property (@(posedge clk_i)
		$fell(rst_i) |-> !ctl_r.trigger_mode_select)
		else $error("trigger mode not cleared by reset");

	a_gate_write: assert property (@(posedge clk_i)
		disable iff (rst_i) wr_setup
		|=> setup_r.count_clock_gate == $past(dat_i[GATE_BIT]))
		else $error("gate bit not stored");

	a_run_write: assert property (@(posedge clk_i)
		disable iff (rst_i) (wr_ctl && !one_shot_done)
		|=> counter_run_o == $past(dat_i[RUN_BIT]))
		else $error("run bit not stored");

	a_trig_write: assert property (@(posedge clk_i)
		disable iff (rst_i) wr_ctl
		|=> ctl_r.trigger_mode_select == $past(dat_i[TRIG_BIT]))
		else $error("trigger mode not stored");

	a_clear_not_held: assert property (@(posedge clk_i)
		disable iff (rst_i) counter_clear_o |=> !counter_clear_o)
		else $error("counter reset held");

	a_undivided_pass: assert property (@(posedge clk_i)
		disable iff (rst_i) (setup_r.count_source_select != SRC_SLOW
			&& setup_r.clock_divider_select == 4'h0 && sel_tick
			&& setup_r.count_clock_gate && ctl_r.counter_run)
		|-> count_en_o)
		else $error("ratio one dropped a tick");

endmodule : pwm_timer_unit

//--- testbench/pwm_timer_unit_tb_top.sv
// Self-checking bench for the PWM timer clock and counter control block.
// Assumes a Wishbone ack one cycle after a request and synced tick inputs.
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
	bad_count++; $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); \
	end end
module pwm_timer_unit_tb_top
	import pwm_clk_pkg::*;
;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              cyc_i = 1'b0;
	logic              stb_i = 1'b0;
	logic              we_i = 1'b0;
	logic [ADDR_W-1:0] adr_i = '0;
	logic [3:0]        sel_i = 4'h0;
	logic [31:0]       dat_i = 32'h0;
	logic [31:0]       dat_o;
	logic              ack_o;
	logic [4:0]        src = 5'h00;
	logic              period_end_i = 1'b0;
	logic              count_en_o;
	logic              counter_clear_o;
	logic              counter_run_o;
	logic              half_period_mode_o;
	logic              compare_buffering_o;
	logic [1:0]        counter_pick_o;
	int                bad_count = 0;
	int                total_checks = 0;
	int                en_cnt = 0;
	int                clr_cnt = 0;
	int                seed = 90330;
	logic [31:0]       q;
	logic [31:0]       v;
	logic [3:0]        cd;
	logic [1:0]        sr;

	always #50 clk_i = ~clk_i;

	pwm_timer_unit dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .fast_osc_a_i(src[1]),
		.fast_osc_b_i(src[0]), .slow_osc_i(src[2]), .ext_clk_i(src[3]),
		.regulated_256hz_tick_i(src[4]), .period_end_i(period_end_i),
		.count_en_o(count_en_o), .counter_clear_o(counter_clear_o),
		.counter_run_o(counter_run_o),
		.half_period_mode_o(half_period_mode_o),
		.compare_buffering_o(compare_buffering_o),
		.counter_pick_o(counter_pick_o)
	);

	// Pulse counters, so one-cycle outputs are never missed
	always @(posedge clk_i) begin
		if (count_en_o === 1'b1)
			en_cnt <= en_cnt + 1;
		if (counter_clear_o === 1'b1)
			clr_cnt <= clr_cnt + 1;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic wb(input logic w, input logic [15:0] idx,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= d;
		sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			conclude();
		end
	endtask : wb

	// Two-cycle high, two-cycle low: safe through the two-stage sync
	task automatic ticks(input int s, input int n, input int exp);
		int e0;
		e0 = en_cnt;
		for (int j = 0; j < n; j++) begin
			@(posedge clk_i);
			src[s] <= 1'b1;
			repeat (2) @(posedge clk_i);
			src[s] <= 1'b0;
			@(posedge clk_i);
		end
		repeat (10) @(posedge clk_i);
		`CHK(en_cnt - e0, exp)
	endtask : ticks

	function automatic logic [31:0] setup_w(logic [3:0] c, logic [1:0] s,
		logic g);
		return {24'h0, c, s, 1'b0, g};
	endfunction : setup_w

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		repeat (50000) @(posedge clk_i);
		bad_count++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK({counter_run_o, half_period_mode_o}, 2'b00)
		wb(1'b0, CLK_SETUP_IDX, 32'h0, 4'hF, q);
		`CHK(q, 32'h0)
		wb(1'b0, CNT_CONTROL_IDX, 32'h0, 4'hF, q);
		`CHK(q, 32'h0)
		wb(1'b0, 16'h5421, 32'h0, 4'hF, q);
		`CHK(q, 32'h0)
		for (int i = 0; i < 6; i++) begin
			v = ($random(seed) & 32'h7D) | 32'h2;
			wb(1'b1, CNT_CONTROL_IDX, v, 4'hF, q);
			repeat (3) @(posedge clk_i);
			`CHK({half_period_mode_o, counter_pick_o, compare_buffering_o},
				v[6:3])
			`CHK(counter_run_o, v[0])
			wb(1'b0, CNT_CONTROL_IDX, 32'h0, 4'hF, q);
			`CHK(q, v & 32'h7D)
		end
		`CHK(clr_cnt, 6)
		wb(1'b1, CLK_SETUP_IDX, 32'hFF, 4'hE, q);
		wb(1'b0, CLK_SETUP_IDX, 32'h0, 4'hF, q);
		`CHK(q, 32'h0)
		wb(1'b1, CNT_CONTROL_IDX, 32'h1, 4'hF, q);
		// Random source and ratio; whole ratio multiples give exact counts
		for (int i = 0; i < 6; i++) begin
			sr = 2'($random(seed));
			cd = 4'($random(seed) & 3);
			wb(1'b1, CLK_SETUP_IDX, setup_w(cd, sr, 1'b1), 4'hF, q);
			wb(1'b0, CLK_SETUP_IDX, 32'h0, 4'hF, q);
			`CHK(q, setup_w(cd, sr, 1'b1))
			ticks(int'(sr), 2 << cd, 2);
		end
		wb(1'b1, CLK_SETUP_IDX, setup_w(4'h1, 2'h1, 1'b0), 4'hF, q);
		ticks(1, 4, 0);
		wb(1'b1, CLK_SETUP_IDX, setup_w(4'hF, 2'h1, 1'b1), 4'hF, q);
		ticks(1, 4, 0);
		wb(1'b1, CLK_SETUP_IDX, setup_w(4'h9, SRC_SLOW, 1'b1), 4'hF, q);
		ticks(4, 3, 3);
		wb(1'b1, CLK_SETUP_IDX, setup_w(4'h0, SRC_EXTERNAL, 1'b1), 4'hF, q);
		ticks(0, 3, 0);
		ticks(3, 3, 3);
		period_end_i <= 1'b1;
		ticks(3, 2, 2);
		wb(1'b1, CNT_CONTROL_IDX, 32'h5, 4'hF, q);
		ticks(3, 2, 1);
		`CHK(counter_run_o, 1'b0)
		wb(1'b0, CNT_CONTROL_IDX, 32'h0, 4'hF, q);
		`CHK(q, 32'h4)
		period_end_i <= 1'b0;
		// Mid-run reset must clear both registers again
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, CLK_SETUP_IDX, 32'h0, 4'hF, q);
		`CHK(q, 32'h0)
		wb(1'b0, CNT_CONTROL_IDX, 32'h0, 4'hF, q);
		`CHK(q, 32'h0)
		conclude();
	end
endmodule : pwm_timer_unit_tb_top
